// ### rtl/pixfmt_pkg.sv
// Constants and carrier types for the pixel output formatter.
// Assumes a single 100 MHz core clock and an externally sampled link clock.
package pixfmt_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADC_W = 10;
    localparam int NUM_CH = 4;
    localparam int WORD_W = 10;
    localparam int CNT_W = 4;

    // Last bit slot of a word: ten slots in 10-bit mode, eight in 8-bit mode
    localparam logic [CNT_W-1:0] LAST_BIT10 = 4'h9;
    localparam logic [CNT_W-1:0] LAST_BIT8 = 4'h7;

    // ------------------------------------------------------------
    // Rate limits (Mbps), pixel rate per channel (Mpix/s) and typical fast clock (MHz)
    // ------------------------------------------------------------
    localparam int MAX_RATE10_MBPS = 620;
    localparam int MAX_RATE8_MBPS = 496;
    localparam int CH_MPIX = 62;
    localparam int FAST_CLK10_MHZ = 310;
    localparam int FAST_CLK8_MHZ = 248;

    // ------------------------------------------------------------
    // Sync codes, arbitrary but distinct; the training word reuses the idle code
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] CODE_FS = 10'h2AA;
    localparam logic [WORD_W-1:0] CODE_LS = 10'h0AA;
    localparam logic [WORD_W-1:0] CODE_FE = 10'h32A;
    localparam logic [WORD_W-1:0] CODE_LE = 10'h12A;
    localparam logic [WORD_W-1:0] CODE_IMG = 10'h035;
    localparam logic [WORD_W-1:0] CODE_CRC = 10'h059;
    localparam logic [WORD_W-1:0] CODE_IDLE = 10'h3A6;
    localparam logic [WORD_W-1:0] TRAIN_WORD = 10'h3A6;

    // CRC-10 polynomial x^10+x^9+x^5+x^4+x+1 and seed
    localparam logic [WORD_W-1:0] CRC_POLY = 10'h233;
    localparam logic [WORD_W-1:0] CRC_SEED = 10'h3FF;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADC_W-1:0] even;
        logic [ADC_W-1:0] odd;
    } adc_pair_s;

    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic line_start;
        logic line_end;
    } timing_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SYNC = 5'h02,
        ST_PIX = 5'h04,
        ST_CRC = 5'h08,
        ST_END = 5'h10
    } phase_e;

endpackage

// ### rtl/pixel_output_formatter.sv
// Pixel output formatter: pair merge, line CRC, sync codes, DDR serialiser.
// Assumes pixel pairs and timing come from the core clock domain; the
// link clock arrives on a pin and is sampled by the core clock.
`timescale 1ns/1ps
`default_nettype none
module pixel_output_formatter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic mode10_i,
    input wire logic fast_clk_sel_i,
    input wire logic [pixfmt_pkg::NUM_CH-1:0] pair_valid_i,
    input wire pixfmt_pkg::adc_pair_s [pixfmt_pkg::NUM_CH-1:0] pair_i,
    input wire pixfmt_pkg::timing_s timing_i,
    output logic pair_ready_o,
    output logic pll_en_o,
    output logic [pixfmt_pkg::NUM_CH-1:0] data_lane_o,
    output logic sync_lane_o,
    output logic clk_lane_o
);

    localparam int N = pixfmt_pkg::NUM_CH;
    localparam int W = pixfmt_pkg::WORD_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] lclk_sync;
        logic lclk_prev;
        pixfmt_pkg::phase_e phase;
        logic odd_sel;
        logic line_open;
        logic frame_end_pend;
        logic [N-1:0][W-1:0] hold;
        logic [N-1:0][W-1:0] crc;
        logic [N-1:0][W-1:0] shift;
        logic [W-1:0] sync_shift;
        logic [N-1:0][W-1:0] next_word;
        logic [W-1:0] next_sync;
        logic word_ready;
        logic [pixfmt_pkg::CNT_W-1:0] bit_cnt;
        logic [N-1:0] lane;
        logic sync_bit;
        logic clk_bit;
        logic pll_en;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // One CRC-10 step over a whole word, MSB first
    function automatic logic [W-1:0] crc_step(input logic [W-1:0] c, input logic [W-1:0] d);
        logic [W-1:0] r;
        r = c;
        for (int b = W - 1; b >= 0; b--) begin
            if (r[W-1] ^ d[b]) begin
                r = {r[W-2:0], 1'b0} ^ pixfmt_pkg::CRC_POLY;
            end else begin
                r = {r[W-2:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Select the word width given to formatting; 8-bit mode drops the two LSBs
    function automatic logic [W-1:0] fmt(input logic [W-1:0] a, input logic m10);
        return m10 ? a : {2'b00, a[W-1:2]};
    endfunction

    logic lclk_edge;
    logic [pixfmt_pkg::CNT_W-1:0] last_bit;

    // Any link clock edge is a bit slot: data leaves on both edges
    assign lclk_edge = state_reg.lclk_sync[1] ^ state_reg.lclk_prev;
    // Bit slots per word follow the mode, setting 10- or 8-bit lane rate
    assign last_bit = mode10_i ? pixfmt_pkg::LAST_BIT10 : pixfmt_pkg::LAST_BIT8;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.lclk_sync = {state_reg.lclk_sync[0], link_clk_i};
        state_next.lclk_prev = state_reg.lclk_sync[1];
        // Fast clock replaces the PLL output, so the PLL is switched off
        state_next.pll_en = ~fast_clk_sel_i;

        // Word formation, one word per serial word time
        if (!state_reg.word_ready) begin
            state_next.word_ready = 1'b1;
            unique case (state_reg.phase)
                pixfmt_pkg::ST_IDLE: begin
                    state_next.next_sync = pixfmt_pkg::CODE_IDLE;
                    for (int i = 0; i < N; i++) begin
                        state_next.next_word[i] = pixfmt_pkg::TRAIN_WORD;
                    end
                    if (timing_i.line_start) begin
                        state_next.phase = pixfmt_pkg::ST_SYNC;
                        state_next.next_sync = timing_i.frame_start ? pixfmt_pkg::CODE_FS
                                                                    : pixfmt_pkg::CODE_LS;
                        for (int i = 0; i < N; i++) begin
                            state_next.crc[i] = pixfmt_pkg::CRC_SEED;
                        end
                    end
                end
                pixfmt_pkg::ST_SYNC, pixfmt_pkg::ST_PIX: begin
                    state_next.phase = pixfmt_pkg::ST_PIX;
                    state_next.next_sync = pixfmt_pkg::CODE_IMG;
                    if (timing_i.line_end && !state_reg.odd_sel) begin
                        state_next.phase = pixfmt_pkg::ST_CRC;
                        state_next.frame_end_pend = timing_i.frame_end;
                        state_next.next_sync = timing_i.frame_end ? pixfmt_pkg::CODE_FE
                                                                  : pixfmt_pkg::CODE_LE;
                        for (int i = 0; i < N; i++) begin
                            state_next.next_word[i] = state_reg.crc[i];
                        end
                    end else begin
                        // Even word from the incoming pair, odd word from the hold
                        for (int i = 0; i < N; i++) begin
                            if (state_reg.odd_sel) begin
                                state_next.next_word[i] = state_reg.hold[i];
                            end else begin
                                state_next.next_word[i] = fmt(pair_i[i].even, mode10_i);
                                state_next.hold[i] = fmt(pair_i[i].odd, mode10_i);
                            end
                            state_next.crc[i] = crc_step(state_reg.crc[i], state_next.next_word[i]);
                        end
                        state_next.odd_sel = ~state_reg.odd_sel;
                    end
                end
                pixfmt_pkg::ST_CRC: begin
                    state_next.phase = pixfmt_pkg::ST_IDLE;
                    state_next.frame_end_pend = 1'b0;
                    state_next.next_sync = pixfmt_pkg::CODE_IDLE;
                    for (int i = 0; i < N; i++) begin
                        state_next.next_word[i] = pixfmt_pkg::TRAIN_WORD;
                    end
                end
                default: begin
                    state_next.phase = pixfmt_pkg::ST_IDLE;
                end
            endcase
        end

        // Serialiser: one bit per link clock edge on every lane
        if (lclk_edge) begin
            state_next.clk_bit = state_reg.lclk_sync[1];
            for (int i = 0; i < N; i++) begin
                state_next.lane[i] = state_reg.shift[i][W-1];
                state_next.shift[i] = {state_reg.shift[i][W-2:0], 1'b0};
            end
            state_next.sync_bit = state_reg.sync_shift[W-1];
            state_next.sync_shift = {state_reg.sync_shift[W-2:0], 1'b0};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
            if (state_reg.bit_cnt == last_bit) begin
                state_next.bit_cnt = '0;
                // Left-align 8-bit words so MSB goes first in either mode
                for (int i = 0; i < N; i++) begin
                    state_next.shift[i] = mode10_i ? state_reg.next_word[i]
                                                   : {state_reg.next_word[i][7:0], 2'b00};
                end
                state_next.sync_shift = mode10_i ? state_reg.next_sync
                                                 : {state_reg.next_sync[7:0], 2'b00};
                state_next.word_ready = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '{
                lclk_sync: 2'b00, lclk_prev: 1'b0, phase: pixfmt_pkg::ST_IDLE,
                odd_sel: 1'b0, line_open: 1'b0, frame_end_pend: 1'b0,
                hold: '0, crc: '0, shift: '0, sync_shift: '0, next_word: '0,
                next_sync: '0, word_ready: 1'b1, bit_cnt: '0, lane: '0,
                sync_bit: 1'b0, clk_bit: 1'b0, pll_en: 1'b1
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // A pair is taken only when the even word is being formed; a line end in
    // that slot sends the CRC instead, so no pair is consumed then
    assign pair_ready_o = ~state_reg.word_ready & ~state_reg.odd_sel
                          & ~timing_i.line_end
                          & (state_reg.phase == pixfmt_pkg::ST_SYNC
                             || state_reg.phase == pixfmt_pkg::ST_PIX);
    assign pll_en_o = state_reg.pll_en;
    assign data_lane_o = state_reg.lane;
    assign sync_lane_o = state_reg.sync_bit;
    assign clk_lane_o = state_reg.clk_bit;

endmodule
`default_nettype wire

// ### tb/pixfmt_asserts.sv
// Port checker for the pixel output formatter.
// Assumes the link clock half period is shorter than 12 core cycles.
`timescale 1ns/1ps
`default_nettype none
module pixfmt_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic fast_clk_sel_i,
    input wire logic pair_ready_o,
    input wire logic pll_en_o,
    input wire logic [pixfmt_pkg::NUM_CH-1:0] data_lane_o,
    input wire logic sync_lane_o,
    input wire logic clk_lane_o
);
    logic link_q;
    logic [3:0] quiet_cnt;
    logic [7:0] gap_cnt;
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Cycles since the last link edge and since the last pair taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_q <= 1'b0;
            quiet_cnt <= 4'h0;
            gap_cnt <= 8'hFF;
        end else begin
            link_q <= link_clk_i;
            quiet_cnt <= (link_clk_i != link_q) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hF};
            gap_cnt <= pair_ready_o ? 8'h00 : gap_cnt + {7'h00, gap_cnt != 8'hFF};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence link_edge;
        $changed(link_clk_i);
    endsequence
    sequence lane_moves;
        ##[1:5] $changed(clk_lane_o);
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    pll_follow_a: assert property (!$past(rst_i) |-> pll_en_o == !$past(fast_clk_sel_i))
        else $error("pll enable does not follow clock select");
    clk_follow_a: assert property (link_edge |-> lane_moves)
        else $error("clock lane missed a link edge");
    clk_quiet_a: assert property (quiet_cnt >= 4'hC |-> $stable(clk_lane_o))
        else $error("clock lane moved without link edge");
    data_quiet_a: assert property (quiet_cnt >= 4'hC |-> $stable(data_lane_o))
        else $error("data lanes moved without link edge");
    sync_quiet_a: assert property (quiet_cnt >= 4'hC |-> $stable(sync_lane_o))
        else $error("sync lane moved without link edge");
    ready_pulse_a: assert property (pair_ready_o |=> !pair_ready_o [*8])
        else $error("pair ready longer than one pulse");
    ready_link_a: assert property (pair_ready_o |-> quiet_cnt < 4'hA)
        else $error("pair taken while link stopped");
    rate_limit_a: assert property (pair_ready_o |-> gap_cnt > 8'h78)
        else $error("pairs taken faster than two words");
endmodule
bind pixel_output_formatter pixfmt_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .fast_clk_sel_i(fast_clk_sel_i), .pair_ready_o(pair_ready_o), .pll_en_o(pll_en_o),
    .data_lane_o(data_lane_o), .sync_lane_o(sync_lane_o), .clk_lane_o(clk_lane_o));
`default_nettype wire

// ### tb/pixfmt_receiver.sv
// Far side model: link clock source and lane deserialiser.
// Assumes the clock lane is registered in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module pixfmt_receiver (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [3:0] data_lane_i,
    input wire logic sync_lane_i,
    input wire logic clk_lane_i,
    output logic link_clk_o,
    output logic [3:0][9:0] data_win_o,
    output logic [9:0] sync_win_o
);
    logic clk_lane_q;
    // Link clock, 160 ns period, parked low between frames
    initial begin
        link_clk_o = 1'b0;
        #3;
        forever begin
            #80;
            if (run_i || link_clk_o) begin
                link_clk_o = ~link_clk_o;
            end
        end
    end
    // One bit per clock lane edge, MSB first, both edges used
    always_ff @(posedge clk_i) begin
        clk_lane_q <= clk_lane_i;
        if (clk_lane_i != clk_lane_q) begin
            for (int i = 0; i < 4; i++) begin
                data_win_o[i] <= {data_win_o[i][8:0], data_lane_i[i]};
            end
            sync_win_o <= {sync_win_o[8:0], sync_lane_i};
        end
    end
endmodule
`default_nettype wire

// ### tb/test_pixel_output_formatter.sv
// Testbench for the pixel output formatter.
// Assumes the receiver model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_pixel_output_formatter;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mode10 = 1'b1;
    logic fast_sel = 1'b0;
    logic run = 1'b0;
    pixfmt_pkg::adc_pair_s [3:0] pairs = {4{20'hB454B}};
    pixfmt_pkg::timing_s timing = '0;
    logic link_clk, pair_ready, pll_en, sync_lane, clk_lane;
    logic [3:0] lanes;
    logic [3:0][9:0] data_win;
    logic [9:0] sync_win, start_code, pix_exp, mask;
    logic [1:0] seen = 2'b00;
    int taken = 0;
    int errors = 0;
    int total_checks = 0;
    pixel_output_formatter dut_u (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .mode10_i(mode10),
        .fast_clk_sel_i(fast_sel), .pair_valid_i(4'hF), .pair_i(pairs), .timing_i(timing),
        .pair_ready_o(pair_ready), .pll_en_o(pll_en), .data_lane_o(lanes), .sync_lane_o(sync_lane),
        .clk_lane_o(clk_lane));
    pixfmt_receiver rx_u (.clk_i(clk_i), .run_i(run), .data_lane_i(lanes), .sync_lane_i(sync_lane),
        .clk_lane_i(clk_lane), .link_clk_o(link_clk), .data_win_o(data_win), .sync_win_o(sync_win));
    // ------------------------------------------------------------
    // Clock, counters and helpers
    // ------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Pairs taken and sticky sightings of the start code and pixel word
    always @(posedge clk_i) begin
        if (pair_ready === 1'b1) taken <= taken + 1;
    end
    always @(negedge clk_i) begin
        if (sync_win === start_code) seen[0] = 1'b1;
        if (((data_win[0] ^ pix_exp) & mask) === 10'h000) seen[1] = 1'b1;
    end
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // Bitwise CRC over alternating even and odd words, MSB first
    function automatic logic [9:0] crc_of(input logic [9:0] w0, input logic [9:0] w1, input int n);
        logic [9:0] c;
        c = pixfmt_pkg::CRC_SEED;
        for (int p = 0; p < 2 * n; p++) begin
            for (int b = 9; b >= 0; b--) begin
                c = {c[8:0], 1'b0} ^ ((c[9] ^ (p[0] ? w1[b] : w0[b])) ? pixfmt_pkg::CRC_POLY : 10'h000);
            end
        end
        return c;
    endfunction
    task automatic wait_taken(input int goal);
        for (int n = 0; n < 1000 && taken < goal; n++) @(negedge clk_i);
        check(taken >= goal, "pair not taken");
        @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_pll();
        fast_sel <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(pll_en === 1'b0, "pll still on with fast clock");
        fast_sel <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(pll_en === 1'b1, "pll off with slow clock");
    endtask
    // One line of two pairs; in 10-bit mode the CRC and end code are judged
    task automatic test_line(input logic first, input logic last, input logic m);
        logic [9:0] crc;
        logic hit;
        crc = crc_of(pairs[0].even, pairs[0].odd, 2);
        start_code = first ? pixfmt_pkg::CODE_FS : pixfmt_pkg::CODE_LS;
        seen = 2'b00;
        hit = 1'b0;
        timing <= '{frame_start: first, frame_end: 1'b0, line_start: 1'b1, line_end: 1'b0};
        wait_taken(taken + 1);
        timing <= '0;
        wait_taken(taken + 1);
        timing <= '{frame_start: 1'b0, frame_end: last, line_start: 1'b0, line_end: 1'b1};
        for (int n = 0; n < 600 && !hit; n++) begin
            @(negedge clk_i);
            hit = m && data_win[0] === crc;
        end
        check(seen[1], "pixel word not seen on lane");
        if (m) begin
            check(hit && data_win[3] === crc, "line CRC wrong");
            check(sync_win === (last ? pixfmt_pkg::CODE_FE : pixfmt_pkg::CODE_LE), "end code");
            check(seen[0], "start code not on sync lane");
        end
        @(posedge clk_i);
        timing <= '0;
    endtask
    task automatic test_frame(input logic m);
        mode10 <= m;
        mask = m ? 10'h3FF : 10'h0FF;
        pix_exp = m ? pairs[0].even : {2'b00, pairs[0].even[9:2]};
        run <= 1'b1;
        // Word alignment of the window depends on where the link clock resumes
        for (int n = 0; n < 400 && !(m && data_win[1] === pixfmt_pkg::TRAIN_WORD); n++) @(negedge clk_i);
        check(!m || data_win[1] === pixfmt_pkg::TRAIN_WORD, "no training word");
        test_line(1'b1, !m, m);
        if (m) test_line(1'b0, 1'b1, m);
        run <= 1'b0;
        repeat (400) @(posedge clk_i);
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        check(pll_en === 1'b1 && lanes === 4'h0 && pair_ready === 1'b0, "reset state");
        @(posedge clk_i);
        rst_i <= 1'b0;
        test_pll();
        test_frame(1'b1);
        test_frame(1'b0);
        give_verdict();
    end
    initial begin
        #300000;
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
